// ===== stjc_pkg.sv
// constants for the stepper jog and standstill current block
// assumes a 125 MHz clock and a classic wishbone master with 32-bit data
package stjc_pkg;
  localparam int          ADR_W      = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_FREQ   = 8'h04;
  localparam logic [7:0]  REG_GAIN   = 8'h08;
  localparam logic [7:0]  REG_RUN    = 8'h0C;
  localparam logic [7:0]  REG_IDLE   = 8'h10;
  localparam logic [7:0]  REG_DLY    = 8'h14;
  localparam logic [7:0]  REG_JSPD   = 8'h18;
  localparam logic [7:0]  REG_JUP    = 8'h1C;
  localparam logic [7:0]  REG_JDN    = 8'h20;
  localparam logic [7:0]  REG_AMAX   = 8'h24;
  localparam logic [7:0]  REG_DIR    = 8'h28;
  localparam logic [7:0]  REG_LIVE   = 8'h2C;
  localparam logic [7:0]  REG_CMD    = 8'h30;
  localparam logic [7:0]  REG_SPDLV  = 8'h34;
  localparam logic [7:0]  REG_STAT   = 8'h38;
  localparam logic [7:0]  REG_FILT   = 8'h3C;
  // control, command, live and status bit positions
  localparam int CTRL_VAR   = 0;
  localparam int CTRL_PDIR  = 1;
  localparam int CTRL_MULTI = 2;
  localparam int CTRL_PROG  = 3;
  localparam int CMD_BEGIN  = 0;
  localparam int CMD_JHALT  = 1;
  localparam int CMD_QHALT  = 2;
  localparam int CMD_MHALT  = 3;
  localparam int LIVE_DIR   = 16;
  localparam int STAT_DIR   = 16;
  localparam int STAT_MOVE  = 17;
  localparam int STAT_RED   = 18;
  localparam int STAT_IN5   = 19;
  localparam int STAT_STATE = 20;
  // limits and reset values
  localparam logic [10:0] FREQ_MIN   = 11'h001;
  localparam logic [10:0] FREQ_MAX   = 11'h7D0;
  localparam logic [10:0] FREQ_RST   = 11'h3E8;
  localparam logic [15:0] GAIN_MAX   = 16'h7FFF;
  localparam logic [14:0] GAIN_RST   = 15'h0000;
  localparam logic [15:0] RUN_RST    = 16'h03E8;
  localparam logic [15:0] IDLE_RST   = 16'h01F4;
  localparam logic [15:0] DLY_MAX    = 16'h03E8;
  localparam logic [15:0] DLY_RST    = 16'h0028;
  localparam logic [15:0] RATE_RST   = 16'h0001;
  localparam logic [7:0]  FILT_RST   = 8'h00;
  localparam logic [19:0] PCT_NUM    = 20'h0_0009;
  localparam logic [19:0] PCT_DEN    = 20'h0_000A;
  // timing: processor tick and delay unit of 10 ms
  localparam int TICK_NS    = 250000;
  localparam int CLK_NS     = 8;
  localparam int TICK_CYC   = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_NS      = 10000000;
  localparam logic [15:0] TICKS_PER_CS = 16'(CS_NS / TICK_NS);
  typedef enum logic [2:0] {
    STJC_IDLE = 3'b001,
    STJC_RUN  = 3'b010,
    STJC_STOP = 3'b100
  } stjc_state_t;
endpackage

// ===== stjc_core.sv
// jog profile, standstill current and filter settings behind a wishbone slave
// assumes a classic wishbone master on clk_i and synchronous pin inputs
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module stjc_core
  import stjc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              step_pulse_i,
  input  wire logic              input_five_i,
  output logic                   input_five_o,
  output logic      [15:0]       phase_cur_o,
  output logic      [15:0]       speed_o,
  output logic                   dir_o,
  output logic                   moving_o,
  output logic      [10:0]       res_freq_o,
  output logic      [14:0]       res_gain_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [15:0] ramp(input logic [15:0] cur, input logic [15:0] tgt,
                                       input logic [15:0] rate);
    if (cur < tgt) return (tgt - cur > rate) ? 16'(cur + rate) : tgt;
    else return (cur - tgt > rate) ? 16'(cur - rate) : tgt;
  endfunction

  function automatic logic [15:0] lim90(input logic [15:0] run);
    return 16'((20'(run) * PCT_NUM) / PCT_DEN);
  endfunction

  logic [31:0]  dat_q, rdata_c, wv;
  logic         ack_q, wr_en;
  logic [3:0]   ctrl_q;
  logic [10:0]  freq_q;
  logic [14:0]  gain_q;
  logic [15:0]  run_q, idle_q, dly_q, jspd_q, jup_q, jdn_q, amax_q;
  logic         dset_q;
  logic [7:0]   filt_q;
  logic [TW-1:0] tick_cnt_q;
  logic         tick_q;
  stjc_state_t  state_q;
  logic [15:0]  spd_q, tgt_q, stop_rate_q, idle_cnt_q, phase_q;
  logic         dir_q, red_q, in5_q;
  logic         moving_q;
  logic [7:0]   fcnt_q;
  logic         prog, cmd_wr, begin_c, jhalt_c, qhalt_c, mhalt_c;
  logic         idle_wr, run_wr;

  // bus slave: answer one cycle after the request, write on the acked edge
  assign wr_en   = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wv      = wmerge(rdata_c, wb_dat_i, wb_sel_i);
  assign prog    = ctrl_q[CTRL_PROG];
  assign cmd_wr  = wr_en && (wb_adr_i == REG_CMD);
  assign begin_c = cmd_wr && wv[CMD_BEGIN];
  assign jhalt_c = cmd_wr && wv[CMD_JHALT] && !prog;
  assign qhalt_c = cmd_wr && wv[CMD_QHALT] && !prog;
  assign mhalt_c = cmd_wr && wv[CMD_MHALT] && (!prog || ctrl_q[CTRL_MULTI]);
  assign idle_wr = wr_en && (wb_adr_i == REG_IDLE);
  assign run_wr  = wr_en && (wb_adr_i == REG_RUN);

  always_comb begin
    rdata_c = '0;
    unique case (wb_adr_i)
      REG_CTRL:  rdata_c[3:0]  = ctrl_q;
      REG_FREQ:  rdata_c[10:0] = freq_q;
      REG_GAIN:  rdata_c[14:0] = gain_q;
      REG_RUN:   rdata_c[15:0] = run_q;
      REG_IDLE:  rdata_c[15:0] = idle_q;
      REG_DLY:   rdata_c[15:0] = dly_q;
      REG_JSPD:  rdata_c[15:0] = jspd_q;
      REG_JUP:   rdata_c[15:0] = jup_q;
      REG_JDN:   rdata_c[15:0] = jdn_q;
      REG_AMAX:  rdata_c[15:0] = amax_q;
      REG_DIR:   rdata_c[0]    = dset_q;
      REG_LIVE:  rdata_c[15:0] = spd_q;
      REG_STAT: begin
        rdata_c[15:0]              = spd_q;
        rdata_c[STAT_DIR]          = dir_q;
        rdata_c[STAT_MOVE]         = (state_q != STJC_IDLE);
        rdata_c[STAT_RED]          = red_q;
        rdata_c[STAT_IN5]          = in5_q;
        rdata_c[STAT_STATE +: 3]   = state_q;
      end
      REG_FILT:  rdata_c[7:0]  = filt_q;
      default:   rdata_c       = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) dat_q <= rdata_c;
    end
  end

  // plain settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      freq_q <= FREQ_RST;
      gain_q <= GAIN_RST;
      dly_q  <= DLY_RST;
      jspd_q <= '0;
      jup_q  <= RATE_RST;
      jdn_q  <= RATE_RST;
      amax_q <= RATE_RST;
      dset_q <= 1'b0;
      filt_q <= FILT_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        REG_CTRL: ctrl_q <= wv[3:0];
        REG_FREQ: freq_q <= (wv[15:0] < 16'(FREQ_MIN)) ? FREQ_MIN :
                            (wv[15:0] > 16'(FREQ_MAX)) ? FREQ_MAX : wv[10:0];
        REG_GAIN: gain_q <= (wv[31:16] != '0 || wv[15:0] > GAIN_MAX) ? GAIN_MAX[14:0]
                            : wv[14:0];
        REG_DLY:  dly_q  <= (wv[15:0] > DLY_MAX) ? DLY_MAX : wv[15:0];
        REG_JSPD: jspd_q <= wv[15:0];
        REG_JUP:  jup_q  <= wv[15:0];
        REG_JDN:  jdn_q  <= wv[15:0];
        REG_AMAX: amax_q <= wv[15:0];
        REG_DIR:  dset_q <= wv[0];
        REG_FILT: filt_q <= wv[7:0];
        default: ;
      endcase
    end
  end

  // run and standstill current with variant dependent clamping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q  <= RUN_RST;
      idle_q <= IDLE_RST;
    end else if (run_wr) begin
      run_q <= wv[15:0];
      if (ctrl_q[CTRL_VAR]) idle_q <= wv[15:0] >> 1;
      else if (wv[15:0] < idle_q) idle_q <= wv[15:0];
    end else if (idle_wr) begin
      if (ctrl_q[CTRL_VAR])
        idle_q <= (wv[15:0] > lim90(run_q)) ? lim90(run_q) : wv[15:0];
      else
        idle_q <= (wv[15:0] > run_q) ? run_q : wv[15:0];
    end
  end

  // processor tick enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TW'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == TW'(TICK_CYCLES - 1)) ? '0 : TW'(tick_cnt_q + 1'b1);
    end
  end

  // input filter counts ticks of disagreement
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in5_q  <= 1'b0;
      fcnt_q <= '0;
    end else if (input_five_i == in5_q) begin
      fcnt_q <= '0;
    end else if (tick_q) begin
      if (fcnt_q >= filt_q) begin
        in5_q  <= input_five_i;
        fcnt_q <= '0;
      end else begin
        fcnt_q <= 8'(fcnt_q + 1'b1);
      end
    end
  end

  // jog state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= STJC_IDLE;
      stop_rate_q <= RATE_RST;
      moving_q    <= 1'b0;
    end else if (begin_c) begin
      state_q  <= STJC_RUN;
      moving_q <= 1'b1;
    end else if (qhalt_c && state_q != STJC_IDLE) begin
      state_q     <= STJC_STOP;
      stop_rate_q <= amax_q;
    end else if ((jhalt_c || mhalt_c) && state_q == STJC_RUN) begin
      state_q     <= STJC_STOP;
      stop_rate_q <= jdn_q;
    end else if (tick_q && state_q == STJC_STOP && spd_q == '0) begin
      state_q  <= STJC_IDLE;
      moving_q <= 1'b0;
    end
  end

  // live target and direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_q <= '0;
      dir_q <= 1'b0;
    end else if (begin_c) begin
      tgt_q <= jspd_q;
      dir_q <= dset_q;
    end else if (wr_en && state_q == STJC_RUN && wb_adr_i == REG_SPDLV) begin
      tgt_q <= wv[15:0];
      dir_q <= wv[LIVE_DIR];
    end else if (wr_en && state_q == STJC_RUN && wb_adr_i == REG_LIVE) begin
      tgt_q <= wv[15:0];
    end
  end

  // speed profile, one step per tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd_q <= '0;
    end else if (tick_q) begin
      unique case (state_q)
        STJC_IDLE: spd_q <= '0;
        STJC_RUN:  spd_q <= ramp(spd_q, tgt_q, (spd_q < tgt_q) ? jup_q : jdn_q);
        STJC_STOP: spd_q <= ramp(spd_q, '0, stop_rate_q);
      endcase
    end
  end

  // standstill delay timer and current selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_q <= '0;
      red_q      <= 1'b0;
      phase_q    <= RUN_RST;
    end else begin
      if (state_q != STJC_IDLE || (ctrl_q[CTRL_PDIR] && step_pulse_i)) begin
        idle_cnt_q <= 16'(dly_q * TICKS_PER_CS);
        red_q      <= 1'b0;
      end else if (tick_q) begin
        if (idle_cnt_q != '0) idle_cnt_q <= 16'(idle_cnt_q - 1'b1);
        else red_q <= 1'b1;
      end
      phase_q <= red_q ? idle_q : run_q;
    end
  end

  assign wb_dat_o     = dat_q;
  assign wb_ack_o     = ack_q;
  assign input_five_o = in5_q;
  assign phase_cur_o  = phase_q;
  assign speed_o      = spd_q;
  assign dir_o        = dir_q;
  // moving flag kept in its own flop so the pin is registered
  assign moving_o     = moving_q;
  assign res_freq_o   = freq_q;
  assign res_gain_o   = gain_q;

  freq_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    freq_q >= FREQ_MIN && freq_q <= FREQ_MAX) else $error("frequency out of range");
  gain_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == REG_GAIN && wv[31:0] > 32'(GAIN_MAX)) |=> gain_q == GAIN_MAX[14:0])
    else $error("gain not clamped");
  idle_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle_wr && !ctrl_q[CTRL_VAR]) |=> idle_q <= $past(run_q) &&
    (idle_q == $past(wv[15:0]) || idle_q == $past(run_q))) else $error("idle clamp wrong");
  run_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_wr && !ctrl_q[CTRL_VAR] && wv[15:0] < idle_q) |=> idle_q == run_q)
    else $error("idle not lowered");
  idle_ninety_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (idle_wr && ctrl_q[CTRL_VAR]) |=> idle_q <= lim90($past(run_q)))
    else $error("idle above ninety percent");
  run_half_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_wr && ctrl_q[CTRL_VAR]) |=> idle_q == (run_q >> 1)) else $error("idle not half");
  step_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q[CTRL_PDIR] && step_pulse_i) |=> !red_q ##1 phase_q == $past(run_q))
    else $error("step pulse did not restart delay");
  reduce_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(red_q) |-> $past(idle_cnt_q) == '0 && $past(state_q) == STJC_IDLE)
    else $error("current reduced early");
  no_overshoot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_q && state_q == STJC_RUN && spd_q <= tgt_q && !wr_en) |=> spd_q <= $past(tgt_q))
    else $error("speed overshoot");
  prog_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cmd_wr && prog && !ctrl_q[CTRL_MULTI] && !wv[CMD_BEGIN] && state_q == STJC_RUN)
    |=> state_q == STJC_RUN) else $error("halt taken from program");
endmodule
`default_nettype wire

// ===== stjc_host.sv
// wishbone host model issuing single register accesses to the jog block
// assumes each task is entered right after a rising edge of clk_i
`timescale 1ns/100ps
`default_nettype none
module stjc_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end
  // hold the request until ack is seen, then release for one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hF;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== stjc_core_tb_top.sv
// self-checking bench for the jog and standstill current block
// assumes stjc_host drives the register bus; tick shortened to 4 clocks
`timescale 1ns/100ps
`default_nettype none
module stjc_core_tb_top
  import stjc_pkg::*;
;
  logic        clk_i, rst_i, step_pulse_i, input_five_i;
  logic        cyc, stb, we, ack, input_five_o, dir_o, moving_o;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] phase_cur_o, speed_o;
  logic [10:0] res_freq_o;
  logic [14:0] res_gain_o;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cyc_cnt = 0;

  stjc_host stjc_host_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  stjc_core #(.TICK_CYCLES(4)) stjc_core_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .step_pulse_i(step_pulse_i),
    .input_five_i(input_five_i), .input_five_o(input_five_o), .phase_cur_o(phase_cur_o),
    .speed_o(speed_o), .dir_o(dir_o), .moving_o(moving_o), .res_freq_o(res_freq_o),
    .res_gain_o(res_gain_o));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic summarize();
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    stjc_host_inst.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] rd;
    stjc_host_inst.xfer(1'b0, a, 32'h0000_0000, rd);
    chk(rd, e);
  endtask
  task automatic ramp(input logic [15:0] tgt, input logic [15:0] rate);
    logic [15:0] prev;
    logic [15:0] dlt;
    int          n;
    prev = speed_o;
    n = 0;
    while (speed_o !== tgt && n < 1000) begin
      @(posedge clk_i);
      n++;
      if (speed_o !== prev) begin
        dlt = (speed_o > prev) ? speed_o - prev : prev - speed_o;
        chk({16'h0000, dlt}, {16'h0000, (speed_o === tgt && dlt < rate) ? dlt : rate});
        prev = speed_o;
      end
    end
    chk({16'h0000, speed_o}, {16'h0000, tgt});
  endtask
  // cycles until standstill current shows
  task automatic idle_time(input int lo, input int hi);
    int n;
    n = 0;
    while (phase_cur_o !== 16'h01F4 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  task automatic pulse();
    step_pulse_i <= 1'b1;
    @(posedge clk_i);
    step_pulse_i <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  task automatic t_settings();
    logic [31:0] fw[3] = '{32'h0000_0000, 32'h0000_0BB8, 32'h0000_0578};
    logic [31:0] fe[3] = '{32'h0000_0001, 32'h0000_07D0, 32'h0000_0578};
    chk({16'h0000, phase_cur_o}, 32'h0000_03E8);
    rdc(REG_FREQ, 32'h0000_03E8);
    rdc(REG_GAIN, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      wr(REG_FREQ, fw[i]);
      rdc(REG_FREQ, fe[i]);
      chk({21'h00_0000, res_freq_o}, fe[i]);
    end
    wr(REG_GAIN, 32'h0000_9C40);
    rdc(REG_GAIN, 32'h0000_7FFF);
    wr(REG_GAIN, 32'h0000_0320);
    chk({17'h0_0000, res_gain_o}, 32'h0000_0320);
  endtask

  task automatic t_cur();
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_IDLE, 32'h0000_05DC);
    rdc(REG_IDLE, 32'h0000_03E8);
    wr(REG_RUN, 32'h0000_012C);
    rdc(REG_IDLE, 32'h0000_012C);
    wr(REG_RUN, 32'h0000_0190);
    rdc(REG_IDLE, 32'h0000_012C);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_RUN, 32'h0000_03E8);
    rdc(REG_IDLE, 32'h0000_01F4);
    wr(REG_IDLE, 32'h0000_03B6);
    rdc(REG_IDLE, 32'h0000_0384);
    wr(REG_RUN, 32'h0000_03E8);
    rdc(REG_IDLE, 32'h0000_01F4);
  endtask

  task automatic t_jog();
    wr(REG_DLY, 32'h0000_0001);
    wr(REG_JSPD, 32'h0000_0014);
    wr(REG_JUP, 32'h0000_0005);
    wr(REG_JDN, 32'h0000_0002);
    wr(REG_AMAX, 32'h0000_000A);
    wr(REG_DIR, 32'h0000_0001);
    wr(REG_CMD, 32'h0000_0001);
    ramp(16'h0014, 16'h0005);
    chk({31'h0, dir_o}, 32'h0000_0001);
    chk({31'h0, moving_o}, 32'h0000_0001);
    wr(REG_SPDLV, 32'h0000_000C);
    ramp(16'h000C, 16'h0002);
    chk({31'h0, dir_o}, 32'h0000_0000);
    rdc(REG_JSPD, 32'h0000_0014);
    wr(REG_CMD, 32'h0000_0002);
    ramp(16'h0000, 16'h0002);
    repeat (12) @(posedge clk_i);
    chk({31'h0, moving_o}, 32'h0000_0000);
    wr(REG_CMD, 32'h0000_0001);
    ramp(16'h0014, 16'h0005);
    chk({31'h0, dir_o}, 32'h0000_0001);
    wr(REG_LIVE, 32'h0000_0008);
    ramp(16'h0008, 16'h0002);
    rdc(REG_JSPD, 32'h0000_0014);
    rdc(REG_DIR, 32'h0000_0001);
    wr(REG_CMD, 32'h0000_0001);
    ramp(16'h0014, 16'h0005);
    wr(REG_CMD, 32'h0000_0004);
    ramp(16'h0000, 16'h000A);
  endtask

  task automatic t_prog();
    wr(REG_CMD, 32'h0000_0001);
    ramp(16'h0014, 16'h0005);
    wr(REG_CTRL, 32'h0000_0009);
    wr(REG_CMD, 32'h0000_0002);
    wr(REG_CMD, 32'h0000_0004);
    wr(REG_CMD, 32'h0000_0008);
    repeat (40) @(posedge clk_i);
    chk({16'h0000, speed_o}, 32'h0000_0014);
    chk({16'h0000, phase_cur_o}, 32'h0000_03E8);
    wr(REG_CTRL, 32'h0000_000D);
    wr(REG_CMD, 32'h0000_0008);
    ramp(16'h0000, 16'h0002);
    wr(REG_CTRL, 32'h0000_0001);
  endtask

  task automatic t_idle();
    logic [31:0] rd;
    idle_time(150, 190);
    wr(REG_DLY, 32'h0000_07D0);
    rdc(REG_DLY, 32'h0000_03E8);
    wr(REG_DLY, 32'h0000_0001);
    pulse();
    chk({16'h0000, phase_cur_o}, 32'h0000_01F4);
    wr(REG_CTRL, 32'h0000_0003);
    pulse();
    chk({16'h0000, phase_cur_o}, 32'h0000_03E8);
    idle_time(140, 190);
    wr(REG_FILT, 32'h0000_0008);
    input_five_i <= 1'b1;
    repeat (24) @(posedge clk_i);
    chk({31'h0, input_five_o}, 32'h0000_0000);
    repeat (32) @(posedge clk_i);
    chk({31'h0, input_five_o}, 32'h0000_0001);
    stjc_host_inst.xfer(1'b0, REG_STAT, 32'h0000_0000, rd);
    chk({31'h0, rd[STAT_IN5]}, 32'h0000_0001);
  endtask

  initial begin
    rst_i = 1'b1;
    step_pulse_i = 1'b0;
    input_five_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_settings();
    t_cur();
    t_jog();
    t_prog();
    t_idle();
    summarize();
  end
endmodule
`default_nettype wire
